// >>> common/mpp_pkg.sv
// ---------------------------------------------------------------
// Motion profile parameter set: shared constants
// ---------------------------------------------------------------
package mpp_pkg;

   // ------------------------------------------------------------
   // Object dictionary indices
   // ------------------------------------------------------------
   localparam logic [15:0] MPP_IDX_JERK = 16'h60a4; // Jerk array
   localparam logic [15:0] MPP_IDX_POS_UNIT = 16'h60a8; // Pos unit
   localparam logic [15:0] MPP_IDX_VEL_UNIT = 16'h60a9; // Vel unit
   localparam logic [15:0] MPP_IDX_POS_OFF = 16'h60b0; // Pos offset
   localparam logic [15:0] MPP_IDX_VEL_OFF = 16'h60b1; // Vel offset
   localparam logic [15:0] MPP_IDX_TRQ_OFF = 16'h60b2; // Trq offset

   // ------------------------------------------------------------
   // Subindices
   // ------------------------------------------------------------
   localparam logic [7:0] MPP_SUB_COUNT = 8'h00; // Entry count
   localparam logic [7:0] MPP_SUB_FIRST = 8'h01; // First jerk entry
   localparam logic [7:0] MPP_SUB_LAST = 8'h04; // Last jerk entry

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] MPP_RST_JERK_COUNT = 8'h04;
   localparam logic [31:0] MPP_RST_JERK = 32'h0000_03e8;
   localparam logic [31:0] MPP_RST_POS_UNIT = 32'hff41_0000;
   localparam logic [31:0] MPP_RST_VEL_UNIT = 32'h00b4_4700;
   localparam logic [31:0] MPP_RST_POS_OFF = 32'h0000_0000;
   localparam logic [31:0] MPP_RST_VEL_OFF = 32'h0000_0000;
   localparam logic [15:0] MPP_RST_TRQ_OFF = 16'h0000;

   // ------------------------------------------------------------
   // Unit descriptor fields
   // ------------------------------------------------------------
   localparam int MPP_EXP_LSB = 24; // Power-of-ten exponent
   localparam int MPP_PUNIT_LSB = 16; // Position unit code
   localparam int MPP_TUNIT_LSB = 8; // Time unit code
   localparam int MPP_FIELD_W = 8; // Every field is one byte
   // Writable bits; reserved bits are dropped on write
   localparam logic [31:0] MPP_POS_UNIT_MASK = 32'hffff_0000;
   localparam logic [31:0] MPP_VEL_UNIT_MASK = 32'hffff_ff00;

   // ------------------------------------------------------------
   // Operating mode codes on op_mode_i
   // ------------------------------------------------------------
   localparam logic [7:0] MPP_MODE_CSP = 8'h08; // Cyclic sync position
   localparam logic [7:0] MPP_MODE_CSV = 8'h09; // Cyclic sync velocity
   localparam logic [7:0] MPP_MODE_CST = 8'h0a; // Cyclic sync torque
   localparam logic [7:0] MPP_MODE_CLKDIR = 8'hff; // Clock-direction

   // Ramp segment currently shaped by the ramp generator
   typedef enum logic [1:0] {
      MPP_PH_ACCEL_BEGIN,
      MPP_PH_BRAKE_BEGIN,
      MPP_PH_ACCEL_END,
      MPP_PH_BRAKE_END
   } mpp_phase_type;

endpackage

// >>> common/mpp_sum_if.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Set value plus offset, between bank and adder
// ---------------------------------------------------------------
interface mpp_sum_if #(
   parameter int W = 32
);
   logic [W-1:0] operand; // Raw set value
   logic [W-1:0] offset; // Signed offset
   logic enable; // Offset applies in the current mode
   logic [W-1:0] sum; // Registered corrected set value

   // Bank side supplies operands
   modport src (
      output operand,
      output offset,
      output enable,
      input sum
   );

   // Adder side returns the sum
   modport adder (
      input operand,
      input offset,
      input enable,
      output sum
   );
endinterface
`default_nettype wire

// >>> rtl/mpp_offset_adder.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Registered signed offset adder
// ---------------------------------------------------------------
module mpp_offset_adder
   import mpp_pkg::*;
#(
   parameter int W = 32
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   mpp_sum_if.adder sum_if
);

   // All state of the adder
   typedef struct packed {
      logic [W-1:0] sum;
   } mpp_add_state_type;

   mpp_add_state_type s_q; // Registered state
   mpp_add_state_type s_d; // Next state

   // Two's complement add; wraps on overflow, no saturation
   always_comb begin
      s_d = s_q;
      if (sum_if.enable) begin
         s_d.sum = W'(sum_if.operand + sum_if.offset);
      end else begin
         s_d.sum = sum_if.operand;
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sum_if.sum = s_q.sum;

endmodule // mpp_offset_adder
`default_nettype wire

// >>> rtl/mpp_param_bank.sv
`timescale 1ns/100ps
`default_nettype none
module mpp_param_bank
   import mpp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Object dictionary access port
   input wire logic od_req_i, // One-cycle access request
   input wire logic od_we_i, // 1 = write, 0 = read
   input wire logic [15:0] od_index_i, // Object index
   input wire logic [7:0] od_sub_i, // Subindex
   input wire logic [31:0] od_wdata_i, // Write data
   output logic od_ack_o, // Answer pulse
   output logic od_abort_o, // Access refused, with ack
   output logic [31:0] od_rdata_o, // Read data, with ack
   // Drive control context
   input wire logic [7:0] op_mode_i, // Active operating mode
   input wire logic [1:0] ramp_phase_i, // Current ramp segment
   input wire logic [31:0] pos_set_i, // Position set value
   input wire logic [31:0] vel_set_i, // Speed set value
   input wire logic [15:0] trq_set_i, // Torque set value
   // Corrected set values
   output logic [31:0] pos_cmd_o,
   output logic [31:0] vel_cmd_o,
   output logic [15:0] trq_cmd_o,
   // Jerk for the current ramp segment
   output logic [31:0] jerk_o,
   output logic jerk_limit_o, // 0 = segment unlimited
   // Unit descriptor fields
   output logic [7:0] pos_exp_o,
   output logic [7:0] pos_unit_o,
   output logic [7:0] vel_exp_o,
   output logic [7:0] vel_pos_unit_o,
   output logic [7:0] vel_time_unit_o
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0][31:0] jerk; // Jerk entries 1..4 at slots 0..3
      logic [31:0] pos_unit; // Position unit descriptor
      logic [31:0] vel_unit; // Velocity unit descriptor
      logic [31:0] pos_off; // Position setpoint offset, signed
      logic [31:0] vel_off; // Speed setpoint offset, signed
      logic [15:0] trq_off; // Torque setpoint offset, 0.1 %, signed
      logic ack; // Answer strobe
      logic abort; // Refusal flag
      logic [31:0] rdata; // Read data
      logic [31:0] jerk_sel; // Selected jerk
      logic jerk_lim; // Selected jerk is a limit
   } mpp_state_type;

   // Power-up contents
   localparam mpp_state_type MPP_STATE_RST = '{
      jerk: {4{MPP_RST_JERK}},
      pos_unit: MPP_RST_POS_UNIT,
      vel_unit: MPP_RST_VEL_UNIT,
      pos_off: MPP_RST_POS_OFF,
      vel_off: MPP_RST_VEL_OFF,
      trq_off: MPP_RST_TRQ_OFF,
      ack: 1'b0,
      abort: 1'b0,
      rdata: 32'h0000_0000,
      jerk_sel: MPP_RST_JERK,
      jerk_lim: 1'b1
   };

   mpp_state_type s_q; // Registered state
   mpp_state_type s_d; // Next state

   // ------------------------------------------------------------
   // Offset adders
   // ------------------------------------------------------------
   mpp_sum_if #(.W(32)) pos_if (); // Position path
   mpp_sum_if #(.W(32)) vel_if (); // Speed path
   mpp_sum_if #(.W(16)) trq_if (); // Torque path

   logic mode_csp; // Cyclic synchronous position
   logic mode_csv; // Cyclic synchronous velocity
   logic mode_cst; // Cyclic synchronous torque
   logic mode_cd; // Clock-direction

   assign mode_csp = (op_mode_i == MPP_MODE_CSP);
   assign mode_csv = (op_mode_i == MPP_MODE_CSV);
   assign mode_cst = (op_mode_i == MPP_MODE_CST);
   assign mode_cd = (op_mode_i == MPP_MODE_CLKDIR);

   // Position setpoint offset only in cyclic position mode
   assign pos_if.operand = pos_set_i;
   assign pos_if.offset = s_q.pos_off;
   assign pos_if.enable = mode_csp;
   // Speed offset in CSP, CSV and clock-direction
   assign vel_if.operand = vel_set_i;
   assign vel_if.offset = s_q.vel_off;
   assign vel_if.enable = mode_csp | mode_csv | mode_cd;
   // Torque setpoint offset in all cyclic modes and clock-direction
   assign trq_if.operand = trq_set_i;
   assign trq_if.offset = s_q.trq_off;
   assign trq_if.enable = mode_csp | mode_csv | mode_cst | mode_cd;

   mpp_offset_adder #(.W(32)) u_pos_add (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .sum_if(pos_if)
   );

   mpp_offset_adder #(.W(32)) u_vel_add (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .sum_if(vel_if)
   );

   mpp_offset_adder #(.W(16)) u_trq_add (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .sum_if(trq_if)
   );

   // ------------------------------------------------------------
   // Next state: dictionary access and jerk selection
   // ------------------------------------------------------------
   logic [1:0] slot; // Jerk slot addressed by subindex
   logic jerk_sub; // Subindex is a jerk entry

   assign slot = 2'(od_sub_i - MPP_SUB_FIRST);
   assign jerk_sub = (od_sub_i >= MPP_SUB_FIRST) &&
                     (od_sub_i <= MPP_SUB_LAST);

   always_comb begin
      logic ok; // Access accepted
      logic [31:0] rd; // Read value before gating
      logic var_sub; // Plain variable takes subindex 0 only
      ok = 1'b0;
      rd = 32'h0000_0000;
      var_sub = (od_sub_i == MPP_SUB_COUNT);
      s_d = s_q;
      s_d.ack = 1'b0;
      s_d.abort = 1'b0;
      s_d.rdata = 32'h0000_0000;
      if (od_req_i) begin
         s_d.ack = 1'b1;
         case (od_index_i)
            MPP_IDX_JERK: begin
               if (var_sub) begin
                  // Entry count is read only
                  rd = {24'h00_0000, MPP_RST_JERK_COUNT};
                  ok = !od_we_i;
               end else if (jerk_sub) begin
                  rd = s_q.jerk[slot];
                  ok = 1'b1;
                  if (od_we_i) begin
                     s_d.jerk[slot] = od_wdata_i;
                  end
               end
            end
            MPP_IDX_POS_UNIT: begin
               rd = s_q.pos_unit;
               ok = var_sub;
               if (var_sub && od_we_i) begin
                  // Only exponent and unit bytes are kept
                  s_d.pos_unit = od_wdata_i &
                                 MPP_POS_UNIT_MASK;
               end
            end
            MPP_IDX_VEL_UNIT: begin
               rd = s_q.vel_unit;
               ok = var_sub;
               if (var_sub && od_we_i) begin
                  // Low byte stays zero
                  s_d.vel_unit = od_wdata_i &
                                 MPP_VEL_UNIT_MASK;
               end
            end
            MPP_IDX_POS_OFF: begin
               rd = s_q.pos_off;
               ok = var_sub;
               if (var_sub && od_we_i) begin
                  s_d.pos_off = od_wdata_i;
               end
            end
            MPP_IDX_VEL_OFF: begin
               rd = s_q.vel_off;
               ok = var_sub;
               if (var_sub && od_we_i) begin
                  s_d.vel_off = od_wdata_i;
               end
            end
            MPP_IDX_TRQ_OFF: begin
               // 16-bit object sits in the low half, upper reads zero
               rd = {16'h0000, s_q.trq_off};
               ok = var_sub;
               if (var_sub && od_we_i) begin
                  s_d.trq_off = od_wdata_i[15:0];
               end
            end
            default: begin
               // Unknown object: refused
               ok = 1'b0;
            end
         endcase
         s_d.abort = !ok;
         // Data only on a good read; writes answer zero
         s_d.rdata = (ok && !od_we_i) ? rd : 32'h0000_0000;
      end
      // Phase code equals slot: start entries first, end entries last
      s_d.jerk_sel = s_q.jerk[ramp_phase_i];
      // A zero entry leaves the segment unshaped
      s_d.jerk_lim = (s_q.jerk[ramp_phase_i] != 32'h0000_0000);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= MPP_STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ------------------------------------------------------------
   assign od_ack_o = s_q.ack;
   assign od_abort_o = s_q.abort;
   assign od_rdata_o = s_q.rdata;
   assign pos_cmd_o = pos_if.sum;
   assign vel_cmd_o = vel_if.sum;
   assign trq_cmd_o = trq_if.sum;
   assign jerk_o = s_q.jerk_sel;
   assign jerk_limit_o = s_q.jerk_lim;
   // Exponent byte in both descriptors
   assign pos_exp_o = s_q.pos_unit[MPP_EXP_LSB +: MPP_FIELD_W];
   assign vel_exp_o = s_q.vel_unit[MPP_EXP_LSB +: MPP_FIELD_W];
   assign pos_unit_o = s_q.pos_unit[MPP_PUNIT_LSB +: MPP_FIELD_W];
   assign vel_pos_unit_o = s_q.vel_unit[MPP_PUNIT_LSB +: MPP_FIELD_W];
   assign vel_time_unit_o =
      s_q.vel_unit[MPP_TUNIT_LSB +: MPP_FIELD_W];

endmodule // mpp_param_bank
`default_nettype wire

// >>> verif/mpp_bank_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------
// Port checker of the parameter bank
// ----------------------------------
module mpp_bank_monitor
   import mpp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic od_req_i,
   input wire logic od_we_i,
   input wire logic [15:0] od_index_i,
   input wire logic [7:0] od_sub_i,
   input wire logic [31:0] od_wdata_i,
   input wire logic od_ack_o,
   input wire logic od_abort_o,
   input wire logic [31:0] od_rdata_o,
   input wire logic [7:0] op_mode_i,
   input wire logic [1:0] ramp_phase_i,
   input wire logic [31:0] pos_set_i,
   input wire logic [31:0] vel_set_i,
   input wire logic [15:0] trq_set_i,
   input wire logic [31:0] pos_cmd_o,
   input wire logic [31:0] vel_cmd_o,
   input wire logic [15:0] trq_cmd_o,
   input wire logic [31:0] jerk_o,
   input wire logic jerk_limit_o,
   input wire logic [7:0] pos_exp_o,
   input wire logic [7:0] pos_unit_o,
   input wire logic [7:0] vel_exp_o,
   input wire logic [7:0] vel_pos_unit_o,
   input wire logic [7:0] vel_time_unit_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Read at subindex zero
   wire rd0 = od_req_i && !od_we_i && od_sub_i == 8'h00;
   // Write to the entry the current segment uses
   wire jerk_wr = od_req_i && od_we_i && od_index_i == MPP_IDX_JERK
      && od_sub_i == {6'h00, ramp_phase_i} + 8'h01;
   // Modes taking the speed offset, and the torque correction
   wire vel_on = op_mode_i inside {MPP_MODE_CSP, MPP_MODE_CSV,
      MPP_MODE_CLKDIR};
   wire trq_on = vel_on || op_mode_i == MPP_MODE_CST;

   chk_ack_next: assert property (od_req_i |=> od_ack_o)
      else $error("request not answered");
   chk_abort_empty: assert property (od_abort_o |->
      od_ack_o && od_rdata_o == 32'h0000_0000) else $error("bad refusal");
   chk_jerk_flag: assert property (
      jerk_limit_o == (jerk_o != 32'h0000_0000)) else $error("limit flag");
   chk_jerk_entry: assert property (
      jerk_wr ##1 (!od_req_i && $stable(ramp_phase_i))
      |=> jerk_o == $past(od_wdata_i, 2)) else $error("wrong jerk entry");
   chk_pos_fields: assert property (
      rd0 && od_index_i == MPP_IDX_POS_UNIT |=>
      od_rdata_o == {pos_exp_o, pos_unit_o, 16'h0000}) else $error("pos unit");
   chk_vel_fields: assert property (
      rd0 && od_index_i == MPP_IDX_VEL_UNIT |=>
      od_rdata_o == {vel_exp_o, vel_pos_unit_o, vel_time_unit_o, 8'h00})
      else $error("vel unit");
   chk_pos_bypass: assert property (op_mode_i != MPP_MODE_CSP |=>
      pos_cmd_o == $past(pos_set_i)) else $error("pos offset leaked");
   chk_vel_bypass: assert property (!vel_on |=>
      vel_cmd_o == $past(vel_set_i)) else $error("vel offset leaked");
   chk_trq_bypass: assert property (!trq_on |=>
      trq_cmd_o == $past(trq_set_i)) else $error("trq offset leaked");
   cover_abort: cover property (od_abort_o);
   cover_jerk: cover property (jerk_wr);
   cover_csp: cover property (op_mode_i == MPP_MODE_CSP);
endmodule // mpp_bank_monitor
`default_nettype wire

// >>> verif/mpp_od_master.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------
// Fieldbus master: one access at a time
// ---------------------------------------
module mpp_od_master (
   input wire logic clk_i,
   input wire logic od_ack_i,
   input wire logic od_abort_i,
   input wire logic [31:0] od_rdata_i,
   output logic od_req_o = 1'b0,
   output logic od_we_o = 1'b0,
   output logic [15:0] od_index_o = 16'h0000,
   output logic [7:0] od_sub_o = 8'h00,
   output logic [31:0] od_wdata_o = 32'h0000_0000
);
   // One pulse request; answer is {ack, abort, rdata}
   task automatic acc(input logic we, input logic [15:0] idx,
      input logic [7:0] sub, input logic [31:0] wd, output logic [33:0] r);
      @(negedge clk_i);
      od_req_o = 1'b1;
      od_we_o = we;
      od_index_o = idx;
      od_sub_o = sub;
      od_wdata_o = wd;
      @(negedge clk_i);
      // Index, subindex and data flip so a stale value never matches
      od_req_o = 1'b0;
      od_index_o = ~idx;
      od_sub_o = ~sub;
      od_wdata_o = ~wd;
      r = {od_ack_i, od_abort_i, od_rdata_i};
   endtask
endmodule // mpp_od_master
`default_nettype wire

// >>> verif/motion_profile_parameter_set_tb.sv
`timescale 1ns/100ps
`default_nettype none
module motion_profile_parameter_set_tb import mpp_pkg::*;;
   // ------------------------------
   // Wiring, tables and helpers
   // ------------------------------
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic od_req_i, od_we_i, od_ack_o, od_abort_o, jerk_limit_o, vm;
   logic [15:0] od_index_i, trq_set_i, trq_cmd_o, to;
   logic [7:0] od_sub_i, op_mode_i, pos_exp_o, pos_unit_o;
   logic [7:0] vel_exp_o, vel_pos_unit_o, vel_time_unit_o;
   logic [31:0] od_wdata_i, od_rdata_o, pos_set_i, vel_set_i, po, vo, w, m;
   logic [31:0] pos_cmd_o, vel_cmd_o, jerk_o;
   logic [31:0] jv [4];
   logic [1:0] ramp_phase_i;
   logic [33:0] r;
   integer seed = 32'h001e;
   int bad_count = 0;
   int cmp_count = 0;
   // Reset reads, refusals, then proof that refusals changed nothing
   logic [15:0] ti [15] = '{16'h60a4, 16'h60a4, 16'h60a4, 16'h60a8,
      16'h60a9, 16'h60b0, 16'h60b1, 16'h60b2, 16'h60a4, 16'h60a4, 16'h60b0,
      16'h60a9, 16'h6000, 16'h60a4, 16'h60b0};
   logic [7:0] ts [15] = '{8'h00, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h05, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
   logic [33:0] te [15] = '{34'h2_0000_0004, 34'h2_0000_03e8,
      34'h2_0000_03e8, 34'h2_ff41_0000, 34'h2_00b4_4700, 34'h2_0000_0000,
      34'h2_0000_0000, 34'h2_0000_0000, 34'h3_0000_0000, 34'h3_0000_0000,
      34'h3_0000_0000, 34'h3_0000_0000, 34'h3_0000_0000, 34'h2_0000_0004,
      34'h2_0000_0000};
   logic [7:0] md [5] = '{8'h08, 8'h09, 8'h0a, 8'hff, 8'h01};

   always #2.5 clk_i = ~clk_i;

   mpp_param_bank dut (.clk_i, .rst_n_i, .od_req_i, .od_we_i, .od_index_i,
      .od_sub_i, .od_wdata_i, .od_ack_o, .od_abort_o, .od_rdata_o, .op_mode_i,
      .ramp_phase_i, .pos_set_i, .vel_set_i, .trq_set_i, .pos_cmd_o,
      .vel_cmd_o, .trq_cmd_o, .jerk_o, .jerk_limit_o, .pos_exp_o, .pos_unit_o,
      .vel_exp_o, .vel_pos_unit_o, .vel_time_unit_o);
   mpp_od_master master (.clk_i, .od_ack_i(od_ack_o), .od_abort_i(od_abort_o),
      .od_rdata_i(od_rdata_o), .od_req_o(od_req_i), .od_we_o(od_we_i),
      .od_index_o(od_index_i), .od_sub_o(od_sub_i), .od_wdata_o(od_wdata_i));

   task chk(input logic [33:0] got, input logic [33:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Answer of an accepted access
   function automatic logic [33:0] ok(input logic [31:0] d);
      return {2'b10, d};
   endfunction
   // Set value plus offset only where the mode takes it; wraps
   function automatic logic [31:0] sum(input logic on, input logic [31:0] a,
      input logic [31:0] b);
      return on ? a + b : a;
   endfunction
   task complete_run;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Watchdog: the run needs under 1000 cycles, 20000 allowed
   initial begin
      #100000;
      bad_count++;
      complete_run();
   end

   initial begin
      op_mode_i = 8'h01;
      ramp_phase_i = 2'h0;
      pos_set_i = 32'h0000_0000;
      vel_set_i = 32'h0000_0000;
      trq_set_i = 16'h0000;
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      rst_n_i = 1'b1;
      for (int k = 0; k < 15; k++) begin
         master.acc(k inside {8, 10, 12}, ti[k], ts[k], 32'hffff_ffff, r);
         chk(r, te[k]);
      end
      // Jerk entries; one zero makes its segment unlimited
      for (int k = 0; k < 4; k++) begin
         jv[k] = (k == 1) ? 32'h0000_0000 : $random(seed);
         master.acc(1'b1, MPP_IDX_JERK, 8'(k + 1), jv[k], r);
         chk(r, ok(32'h0000_0000));
      end
      for (int k = 3; k >= 0; k--) begin
         @(negedge clk_i);
         ramp_phase_i = 2'(k);
         @(negedge clk_i);
         chk({jerk_limit_o, jerk_o}, {jv[k] != 0, jv[k]});
      end
      // Descriptors: reserved bits dropped, fields on the outputs
      for (int k = 0; k < 2; k++) begin
         w = $random(seed);
         m = k ? 32'hffff_ff00 : 32'hffff_0000;
         master.acc(1'b1, k ? MPP_IDX_VEL_UNIT : MPP_IDX_POS_UNIT, 8'h00, w, r);
         master.acc(1'b0, k ? MPP_IDX_VEL_UNIT : MPP_IDX_POS_UNIT, 8'h00, w, r);
         chk(r, ok(w & m));
         chk(k ? {vel_exp_o, vel_pos_unit_o, vel_time_unit_o, 8'h00}
            : {pos_exp_o, pos_unit_o, 16'h0000}, w & m);
      end
      // Offsets with wrapping corners, then every mode twice
      po = 32'h7fff_ffff;
      vo = $random(seed);
      to = 16'h8000;
      master.acc(1'b1, MPP_IDX_POS_OFF, 8'h00, po, r);
      master.acc(1'b1, MPP_IDX_VEL_OFF, 8'h00, vo, r);
      master.acc(1'b1, MPP_IDX_TRQ_OFF, 8'h00, {16'hffff, to}, r);
      master.acc(1'b0, MPP_IDX_TRQ_OFF, 8'h00, 32'h0000_0000, r);
      chk(r, ok({16'h0000, to}));
      for (int k = 0; k < 10; k++) begin
         @(negedge clk_i);
         op_mode_i = md[k % 5];
         vm = md[k % 5] inside {8'h08, 8'h09, 8'hff};
         pos_set_i = $random(seed);
         vel_set_i = $random(seed);
         trq_set_i = 16'($random(seed));
         @(negedge clk_i);
         chk(pos_cmd_o, sum(op_mode_i == 8'h08, pos_set_i, po));
         chk(vel_cmd_o, sum(vm, vel_set_i, vo));
         chk(trq_cmd_o, 16'(sum(vm || op_mode_i == 8'h0a,
            {16'h0000, trq_set_i}, {16'h0000, to})));
      end
      complete_run();
   end
endmodule // motion_profile_parameter_set_tb
bind mpp_param_bank mpp_bank_monitor mon (.clk_i, .rst_n_i, .od_req_i,
   .od_we_i, .od_index_i, .od_sub_i, .od_wdata_i, .od_ack_o, .od_abort_o,
   .od_rdata_o, .op_mode_i, .ramp_phase_i, .pos_set_i, .vel_set_i,
   .trq_set_i, .pos_cmd_o, .vel_cmd_o, .trq_cmd_o, .jerk_o, .jerk_limit_o,
   .pos_exp_o, .pos_unit_o, .vel_exp_o, .vel_pos_unit_o, .vel_time_unit_o);
`default_nettype wire
